// [design/calc_pkg.sv]
package calc_pkg;
  // data width: percent in fixed point, FRAC fractional bits
  localparam int DATA_W = 16;
  localparam int FRAC = 8;
  localparam logic [15:0] PCT_ONE = 16'h0100;   // 1.0 (also the logic true threshold of the math stages)
  localparam logic [15:0] PCT_FULL = 16'h6400;  // 100.0 percent
  localparam logic [15:0] PCT_ZERO = 16'h0000;
  localparam int N_MATH = 5;
  localparam int N_IN = 6;
  localparam int N_STAGE = 4;
  localparam int N_COND = 4;
  localparam logic [2:0] SRC_UNUSED = 3'h0;
  // register map (byte addresses)
  localparam logic [11:0] ADDR_CTRL = 12'h000;      // bit0 math enable mask .. bits
  localparam logic [11:0] ADDR_DATA_BASE = 12'h100; // input data words
  localparam logic [11:0] ADDR_MATH_BASE = 12'h200; // per block: 16 words
  localparam logic [11:0] ADDR_COND_BASE = 12'h400; // per block: 4 words
  localparam logic [11:0] ADDR_MRES_BASE = 12'h500; // math results
  localparam logic [11:0] ADDR_CRES = 12'h580;      // conditional results
  localparam int N_DATA = 16;                       // data words in input pool
  localparam int MATH_WORDS = 16;
  localparam int COND_WORDS = 4;
  // math operator codes
  typedef enum logic [3:0] {
    OP_EQ, OP_NE, OP_GT, OP_GE, OP_LT, OP_LE, OP_OR, OP_AND, OP_XOR,
    OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_MIN, OP_MAX
  } math_op_t;
  // combine codes
  localparam logic [1:0] COMB_OR = 2'h0;
  localparam logic [1:0] COMB_AND = 2'h1;
  localparam logic [1:0] COMB_XOR = 2'h2;
  localparam logic [2:0] CMP_OR = 3'h6;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// [design/math_stage.sv]
`timescale 1ns/1ps
// one A-operator-B stage, combinational
module math_stage
  import calc_pkg::*;
(
  input wire logic [15:0] operand_a,
  input wire logic [15:0] operand_b,
  input wire logic [3:0] op,
  input wire logic b_used,
  output logic [15:0] result
);
  logic [16:0] sum;
  logic [16:0] dif;
  logic [31:0] prod;
  logic [23:0] quot;
  logic ta;
  logic tb;
  logic [15:0] r;
  // truth, sum, product and quotient helpers
  always_comb begin
    ta = operand_a >= PCT_ONE;
    tb = operand_b >= PCT_ONE;
    sum = {1'b0, operand_a} + {1'b0, operand_b};
    dif = {1'b0, operand_a} - {1'b0, operand_b};
    prod = (32'(operand_a) * 32'(operand_b)) >> FRAC;
    quot = (operand_b == PCT_ZERO) ? 24'h0 : 24'(({8'h0, operand_a} << FRAC) / operand_b);
  end
  // operator select with saturation to full scale
  always_comb begin
    r = PCT_ZERO;
    case (op)
      4'h0: r = (operand_a == operand_b) ? PCT_ONE : PCT_ZERO;
      4'h1: r = (operand_a != operand_b) ? PCT_ONE : PCT_ZERO;
      4'h2: r = (operand_a > operand_b) ? PCT_ONE : PCT_ZERO;
      4'h3: r = (operand_a >= operand_b) ? PCT_ONE : PCT_ZERO;
      4'h4: r = (operand_a < operand_b) ? PCT_ONE : PCT_ZERO;
      4'h5: r = (operand_a <= operand_b) ? PCT_ONE : PCT_ZERO;
      4'h6: r = (ta | tb) ? PCT_ONE : PCT_ZERO;
      4'h7: r = (ta & tb) ? PCT_ONE : PCT_ZERO;
      4'h8: r = (ta ^ tb) ? PCT_ONE : PCT_ZERO;
      4'h9: r = (sum > {1'b0, PCT_FULL}) ? PCT_FULL : sum[15:0];
      4'ha: r = dif[16] ? PCT_ZERO : dif[15:0];
      4'hb: r = (prod > 32'(PCT_FULL)) ? PCT_FULL : prod[15:0];
      4'hc: begin
        if (operand_b == PCT_ZERO) begin
          r = PCT_FULL;
        end else begin
          r = (quot > 24'(PCT_FULL)) ? PCT_FULL : quot[15:0];
        end
      end
      4'hd: r = (operand_a < operand_b) ? operand_a : operand_b;
      4'he: r = (operand_a > operand_b) ? operand_a : operand_b;
      default: r = PCT_ZERO;
    endcase
  end
  // unused B passes A untouched
  assign result = b_used ? r : operand_a;
endmodule

// [design/calc_blocks.sv]
`timescale 1ns/1ps
module calc_blocks
  import calc_pkg::*;
#(
  parameter int N_MATH_P = N_MATH,
  parameter int N_COND_P = N_COND
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [N_MATH_P-1:0] math_enabled,
  output logic [N_COND_P-1:0] cond_out
);
  // data pool: words that other blocks would supply, source index 1..15
  logic [15:0] pool_r [N_DATA];
  logic [31:0] ctrl_r;
  // math config per block: words 0-5 input cfg, 6-9 stage cfg, 10 out range
  logic [31:0] mcfg_r [N_MATH_P][MATH_WORDS];
  // cond config: word0 cond1, word1 cond2, word2 combine
  logic [31:0] ccfg_r [N_COND_P][COND_WORDS];
  logic [15:0] mres_r [N_MATH_P];
  logic [N_COND_P-1:0] cres_r;

  logic aw_have_r;
  logic w_have_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  logic [11:0] wa;
  logic wr_ok;

  // write address and data latched independently
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wa = awaddr_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) m[i*8 +: 8] = nw[i*8 +: 8];
    end
    return m;
  endfunction

  // write decode, default config keeps cond operators at OR
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_r <= 32'h0;
      for (int i = 0; i < N_DATA; i++) pool_r[i] <= PCT_ZERO;
      for (int m = 0; m < N_MATH_P; m++) begin
        for (int w = 0; w < MATH_WORDS; w++) mcfg_r[m][w] <= 32'h0;
      end
      for (int c = 0; c < N_COND_P; c++) begin
        ccfg_r[c][0] <= {29'h0, CMP_OR};
        ccfg_r[c][1] <= {29'h0, CMP_OR};
        ccfg_r[c][2] <= 32'h0;
        ccfg_r[c][3] <= 32'h0;
      end
    end else if (do_write) begin
      if (wa == ADDR_CTRL) ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
      for (int i = 0; i < N_DATA; i++) begin
        if (wa == ADDR_DATA_BASE + 12'(i*4)) begin
          pool_r[i] <= 16'(merge({16'h0, pool_r[i]}, wdata_r, wstrb_r));
        end
      end
      for (int m = 0; m < N_MATH_P; m++) begin
        for (int w = 0; w < MATH_WORDS; w++) begin
          if (wa == ADDR_MATH_BASE + 12'((m*MATH_WORDS + w)*4)) begin
            mcfg_r[m][w] <= merge(mcfg_r[m][w], wdata_r, wstrb_r);
          end
        end
      end
      for (int c = 0; c < N_COND_P; c++) begin
        for (int w = 0; w < COND_WORDS; w++) begin
          if (wa == ADDR_COND_BASE + 12'((c*COND_WORDS + w)*4)) begin
            ccfg_r[c][w] <= merge(ccfg_r[c][w], wdata_r, wstrb_r);
          end
        end
      end
    end
  end

  // address check for both directions
  function automatic logic mapped(input logic [11:0] a);
    logic ok;
    ok = (a == ADDR_CTRL) || (a == ADDR_CRES);
    if (a >= ADDR_DATA_BASE && a < ADDR_DATA_BASE + 12'(N_DATA*4)) ok = 1'b1;
    if (a >= ADDR_MATH_BASE && a < ADDR_MATH_BASE + 12'(N_MATH_P*MATH_WORDS*4)) ok = 1'b1;
    if (a >= ADDR_COND_BASE && a < ADDR_COND_BASE + 12'(N_COND_P*COND_WORDS*4)) ok = 1'b1;
    if (a >= ADDR_MRES_BASE && a < ADDR_MRES_BASE + 12'(N_MATH_P*4)) ok = 1'b1;
    return ok && (a[1:0] == 2'b00);
  endfunction
  assign wr_ok = mapped(wa) && !(wa == ADDR_CRES) && !(wa >= ADDR_MRES_BASE);

  // write response
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel, one cycle after address
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
      s_axi_rdata <= 32'h0;
      if (s_axi_araddr == ADDR_CTRL) s_axi_rdata <= ctrl_r;
      if (s_axi_araddr == ADDR_CRES) s_axi_rdata <= 32'(cres_r);
      for (int i = 0; i < N_DATA; i++) begin
        if (s_axi_araddr == ADDR_DATA_BASE + 12'(i*4)) s_axi_rdata <= {16'h0, pool_r[i]};
      end
      for (int m = 0; m < N_MATH_P; m++) begin
        if (s_axi_araddr == ADDR_MRES_BASE + 12'(m*4)) s_axi_rdata <= {16'h0, mres_r[m]};
        for (int w = 0; w < MATH_WORDS; w++) begin
          if (s_axi_araddr == ADDR_MATH_BASE + 12'((m*MATH_WORDS + w)*4)) begin
            s_axi_rdata <= mcfg_r[m][w];
          end
        end
      end
      for (int c = 0; c < N_COND_P; c++) begin
        for (int w = 0; w < COND_WORDS; w++) begin
          if (s_axi_araddr == ADDR_COND_BASE + 12'((c*COND_WORDS + w)*4)) begin
            s_axi_rdata <= ccfg_r[c][w];
          end
        end
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // input word: [3:0] source, [15:8] min, [23:16] max, [31:24] gain (percent units)
  function automatic logic [15:0] scale_in(input logic [31:0] cfg, input logic [15:0] raw);
    logic [31:0] g;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] v;
    g = (cfg[31:24] == 8'h0) ? 32'h1 : 32'(cfg[31:24]);
    lo = 32'(cfg[15:8]) * g;
    hi = 32'(cfg[23:16]) * g;
    v = 32'(raw[15:FRAC]) * g;
    if (cfg[3:0] == 4'h0 || hi <= lo) return PCT_ZERO;
    if (v <= lo) return PCT_ZERO;
    if (v >= hi) return PCT_FULL;
    return 16'(((v - lo) * 32'(PCT_FULL)) / (hi - lo));
  endfunction

  // per math block: scale inputs, chain four stages, map to output range
  genvar gm;
  generate
    for (gm = 0; gm < N_MATH_P; gm++) begin : g_math
      logic [15:0] pct [N_IN];
      logic [15:0] chain [N_STAGE+1];
      for (genvar k = 0; k < N_IN; k++) begin : g_in
        assign pct[k] = scale_in(mcfg_r[gm][k], pool_r[mcfg_r[gm][k][3:0]]);
      end
      // stage word: [2:0] B input (0 none), [6:4] A input (first stage word only), [11:8] op
      assign chain[0] = pct[3'(mcfg_r[gm][N_IN][6:4]) % 3'(N_IN)];
      for (genvar s = 0; s < N_STAGE; s++) begin : g_st
        logic [2:0] bsel;
        assign bsel = mcfg_r[gm][N_IN+s][2:0];
        math_stage u_stage (
          .operand_a(chain[s]),
          .operand_b((bsel == SRC_UNUSED || bsel > 3'(N_IN)) ? PCT_ZERO : pct[bsel-3'h1]),
          .op(mcfg_r[gm][N_IN+s][11:8]),
          .b_used(bsel != SRC_UNUSED),
          .result(chain[s+1])
        );
      end
      // range word: [15:0] min, [31:16] max
      logic [31:0] span;
      logic [31:0] outv;
      assign span = 32'(mcfg_r[gm][N_IN+N_STAGE][31:16]) - 32'(mcfg_r[gm][N_IN+N_STAGE][15:0]);
      assign outv = 32'(mcfg_r[gm][N_IN+N_STAGE][15:0])
                  + (32'(chain[N_STAGE]) * span) / 32'(PCT_FULL);
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          mres_r[gm] <= PCT_ZERO;
        end else begin
          mres_r[gm] <= ctrl_r[gm] ? outv[15:0] : PCT_ZERO;
        end
      end
      assign math_enabled[gm] = ctrl_r[gm];
    end
  endgenerate

  // argument compare
  function automatic logic cmp(input logic [2:0] op, input logic [15:0] a, input logic [15:0] b);
    case (op)
      3'h0: return a == b;
      3'h1: return a != b;
      3'h2: return a > b;
      3'h3: return a >= b;
      3'h4: return a < b;
      3'h5: return a <= b;
      3'h6: return (a != 16'h0) || (b != 16'h0);
      3'h7: return (a != 16'h0) && (b != 16'h0);
      default: return 1'b0;
    endcase
  endfunction

  // cond word: [2:0] op, [11:8] arg1 src, [15:12] arg2 src (0 none)
  genvar gc;
  generate
    for (gc = 0; gc < N_COND_P; gc++) begin : g_cond
      logic [1:0] hit;
      for (genvar q = 0; q < 2; q++) begin : g_q
        logic [15:0] a1;
        logic [15:0] a2;
        assign a1 = (ccfg_r[gc][q][11:8] == 4'h0) ? PCT_ZERO : pool_r[ccfg_r[gc][q][11:8]];
        assign a2 = (ccfg_r[gc][q][15:12] == 4'h0) ? PCT_ZERO : pool_r[ccfg_r[gc][q][15:12]];
        assign hit[q] = cmp(ccfg_r[gc][q][2:0], a1, a2);
      end
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          cres_r[gc] <= 1'b0;
        end else begin
          case (ccfg_r[gc][2][1:0])
            COMB_OR: cres_r[gc] <= hit[0] | hit[1];
            COMB_AND: cres_r[gc] <= hit[0] & hit[1];
            COMB_XOR: cres_r[gc] <= hit[0] ^ hit[1];
            default: cres_r[gc] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate
  assign cond_out = cres_r;
endmodule

// [bench/calc_blocks_chk.sv]
`timescale 1ns/1ps
// port-level watch of bus answers and results
module calc_blocks_chk
  import calc_pkg::*;
#(
  parameter int N_MATH_P = N_MATH,
  parameter int N_COND_P = N_COND
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [N_MATH_P-1:0] math_enabled,
  input wire logic [N_COND_P-1:0] cond_out
);
  logic [11:0] wa_r;
  logic [11:0] ra_r;
  logic [31:0] wd_r;
  // last accepted write and read targets
  always_ff @(posedge clk_sys) begin
    if (s_axi_awvalid && s_axi_awready) begin
      wa_r <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wd_r <= s_axi_wdata;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      ra_r <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  a_result_clamp: assert property (
    s_axi_rvalid && s_axi_rresp == AXI_OKAY && ra_r[11:7] == 5'h0a |-> s_axi_rdata <= 32'h6400)
    else $error("math result above full scale");
  a_ctrl_enable: assert property (
    $rose(s_axi_bvalid) && wa_r == ADDR_CTRL && s_axi_bresp == AXI_OKAY
    |-> math_enabled == wd_r[N_MATH_P-1:0]) else $error("enable mask not applied");
  a_reset_quiet: assert property ($rose(rst_n) |-> cond_out == '0 && !s_axi_bvalid)
    else $error("outputs not quiet after reset");
endmodule

bind calc_blocks calc_blocks_chk #(.N_MATH_P(N_MATH_P), .N_COND_P(N_COND_P)) calc_blocks_chk_inst (
  .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .math_enabled, .cond_out);

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import calc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [N_MATH-1:0] math_enabled;
  logic [N_COND-1:0] cond_out;
  int n_mismatch = 0;
  int n_tests = 0;
  // op results for A=20 B=30 in 8.8 percent, divide truncates
  logic [15:0] mexp [15] = '{16'h0, 16'h0100, 16'h0, 16'h0, 16'h0100, 16'h0100, 16'h0100,
    16'h0100, 16'h0, 16'h3200, 16'h0, 16'h6400, 16'h00aa, 16'h1400, 16'h1e00};

  calc_blocks #(.N_MATH_P(N_MATH), .N_COND_P(N_COND)) calc_blocks_inst (
    .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .math_enabled, .cond_out);

  // 25 MHz clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tmo(input logic done);
    if (!done) begin
      n_mismatch++;
      $display("[FAIL] %0t bus timeout", $time);
      finish_test();
    end
  endtask

  // bus write, both halves offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic aw, w, b;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    b = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b && n < 60) begin
      @(posedge clk_sys);
      n++;
      b = s_axi_bvalid;
      rsp = s_axi_bresp;
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b0;
    tmo(b);
  endtask

  // bus read
  task automatic rdw(input logic [11:0] a);
    int n;
    logic ar, r;
    n = 0;
    ar = 1'b0;
    r = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r && n < 60) begin
      @(posedge clk_sys);
      n++;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      if (!ar && s_axi_arready) begin
        ar = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
    s_axi_rready <= 1'b0;
    tmo(r);
  endtask

  task automatic mw(input int w, input logic [31:0] d);
    wr(ADDR_MATH_BASE + 12'(4 * w), d);
  endtask

  task automatic mchk(input logic [15:0] e, input string s);
    rdw(ADDR_MRES_BASE);
    chk(rd, {16'h0, e}, s);
  endtask

  task automatic t_reset;
    rdw(ADDR_COND_BASE);
    chk(rd, 32'h6, "cond op1 default");
    rdw(ADDR_COND_BASE + 12'h004);
    chk(rd, 32'h6, "cond op2 default");
    chk(32'(cond_out), 32'h0, "cond out idle");
    $display("test reset done");
  endtask

  task automatic t_bus_err;
    rdw(12'hffc);
    chk({30'h0, rsp}, {30'h0, AXI_SLVERR}, "unmapped read");
    chk(rd, 32'h0, "unmapped data");
    wr(ADDR_MRES_BASE, 32'h1);
    chk({30'h0, rsp}, {30'h0, AXI_SLVERR}, "result write");
    $display("test bus errors done");
  endtask

  // A=in0 (20%), B=in1 (30%), in2 reads zero
  task automatic t_math_ops;
    wr(ADDR_CTRL, 32'h1);
    chk(32'(math_enabled), 32'h1, "math enable");
    wr(ADDR_DATA_BASE + 12'h004, 32'h1400);
    wr(ADDR_DATA_BASE + 12'h008, 32'h1e00);
    wr(ADDR_DATA_BASE + 12'h00c, 32'h0);
    mw(0, 32'h01640001);
    mw(1, 32'h01640002);
    mw(2, 32'h01640003);
    mw(10, 32'h64000000);
    for (int op = 0; op < 15; op++) begin
      mw(6, (32'(op) << 8) | 32'h2);
      mchk(mexp[op], "stage op");
    end
    $display("test math ops done");
  endtask

  task automatic t_math_misc;
    mw(6, 32'h0c03);
    mchk(16'h6400, "divide by zero");
    mw(6, 32'h0902);
    mw(7, 32'h0a01);
    mw(8, 32'h0e01);
    mchk(16'h1e00, "chained stages");
    mw(7, 32'h0);
    mw(8, 32'h0);
    mw(6, 32'h0010);
    mchk(16'h1e00, "A select pass");
    mw(0, 32'h01c80001);
    mw(6, 32'h0);
    mchk(16'h0a00, "input span");
    mw(0, 32'h01640001);
    mw(10, 32'h32000000);
    mchk(16'h0a00, "output range");
    mw(10, 32'h64000000);
    wr(ADDR_DATA_BASE + 12'h004, 32'h3c00);
    wr(ADDR_DATA_BASE + 12'h008, 32'h3200);
    mw(6, 32'h0902);
    mchk(16'h6400, "sum saturates");
    $display("test math misc done");
  endtask

  task automatic cset(input logic [31:0] c1, input logic [31:0] c2, input logic [31:0] k);
    wr(ADDR_COND_BASE, c1);
    wr(ADDR_COND_BASE + 12'h004, c2);
    wr(ADDR_COND_BASE + 12'h008, k);
    repeat (3) @(posedge clk_sys);
  endtask

  // arg1=pool1 (20), arg2=pool2 (30); cond2 at OR with no args in the op sweep, EQ with no args in combine
  task automatic t_cond;
    logic [7:0] cexp;
    logic [3:0] kexp;
    cexp = 8'hf2;
    kexp = 4'h5;
    wr(ADDR_DATA_BASE + 12'h004, 32'h1400);
    wr(ADDR_DATA_BASE + 12'h008, 32'h1e00);
    for (int op = 0; op < 8; op++) begin
      cset(32'h2100 | 32'(op), 32'h6, 32'h0);
      chk({31'h0, cond_out[0]}, {31'h0, cexp[op]}, "arg compare");
    end
    for (int k = 0; k < 4; k++) begin
      cset(32'h2102, 32'h0, 32'(k));
      chk({31'h0, cond_out[0]}, {31'h0, kexp[k]}, "combine");
    end
    wr(ADDR_DATA_BASE, 32'h7f00);
    cset(32'h2104, 32'h1004, 32'h1);
    chk({31'h0, cond_out[0]}, 32'h1, "unused args");
    $display("test conditional done");
  endtask

  // reset, then scenarios
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_bus_err();
    t_math_ops();
    t_math_misc();
    t_cond();
    finish_test();
  end
endmodule
